// File: design/sor_safe_output.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Every digital pad level is readable through its input path for internal read-back.
// - External read-back loops an even pad's output to its odd partner input pad off chip.
// - Pads without a dedicated function work as general-purpose input or output.
// - Analog-reserved pads stay inputs and can never drive.
// - Masked parallel write updates two or more output pads in one access.
// - Only pads whose mask bit is set change on a masked write.
// - Capture timers 0,1,2 pair with pwm units 0,1,0 respectively.
// - One capture channel muxes among six pwm read-back paths.
module sor_safe_output
	import sor_pkg::*;
#(
	parameter int N = SOR_NUM_PADS
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// Pad configuration
	input  wire logic [N-1:0]            analog_pad,
	input  wire logic [N-1:0]            dir_out,
	input  wire logic [N-1:0]            ext_pair_en,
	input  wire logic [2:0]              check_mode,
	// Single pad write
	input  wire logic                    pad_wr,
	input  wire logic [N-1:0]            pad_wr_sel,
	input  wire logic [N-1:0]            pad_wr_data,
	// Masked parallel data out
	input  wire logic                    masked_parallel_data_out_wr,
	input  wire logic [N-1:0]            mpdo_mask,
	input  wire logic [N-1:0]            mpdo_data,
	// Pads
	input  wire logic [N-1:0]            pad_in,
	output logic      [N-1:0]            pad_out_r,
	output logic      [N-1:0]            pad_oe_r,
	// Read-back status
	output logic      [N-1:0]            pad_level_r,
	output logic      [N-1:0]            mismatch_r,
	// Pwm read-back
	input  wire logic [SOR_RB_PATHS-1:0] pwm_unit_0_rb,
	input  wire logic [SOR_RB_PATHS-1:0] pwm_unit_1_rb,
	input  wire logic [SOR_RB_SEL_W-1:0] capt_sel [SOR_NUM_CAPT],
	output logic      [SOR_NUM_CAPT-1:0] capt_value_r
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [N-1:0] pin_meta_r;
	logic [N-1:0] pin_sync_r;
	logic [N-1:0] dout_r;
	logic [N-1:0] dout_nxt;
	logic [N-1:0] oe_nxt;
	logic [3:0]   settle_r;

	// Two stages before anything reads the pad level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pad_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// Readable level of every pad, whatever its direction
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pad_level_r <= SOR_DOUT_RST;
		end else begin
			pad_level_r <= pin_sync_r;
		end
	end

	// ----------------------------------------------------------------
	// Output data and direction
	// ----------------------------------------------------------------
	// Masked write touches only masked pads; single write by select
	always_comb begin
		dout_nxt = dout_r;
		if (masked_parallel_data_out_wr) begin
			dout_nxt = (dout_r & ~mpdo_mask) | (mpdo_data & mpdo_mask);
		end else if (pad_wr) begin
			dout_nxt = (dout_r & ~pad_wr_sel) | (pad_wr_data & pad_wr_sel);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dout_r <= SOR_DOUT_RST;
		end else begin
			dout_r <= dout_nxt;
		end
	end

	// Analog pads can never be enabled as drivers
	assign oe_nxt = dir_out & ~analog_pad;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pad_out_r <= SOR_DOUT_RST;
			pad_oe_r  <= SOR_DIR_RST;
		end else begin
			pad_out_r <= dout_r;
			pad_oe_r  <= oe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Mismatch detection
	// ----------------------------------------------------------------
	// Hold-off after any change so pad and sync delay can settle
	// Four edges cover the output flop plus the three-stage level path
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			settle_r <= '0;
		end else begin
			settle_r <= {settle_r[2:0], (dout_nxt != dout_r) || (oe_nxt != pad_oe_r)};
		end
	end

	// Sticky per pad; cleared when a write changes the pad's output value, set wins
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_cmp
			logic expect_v;
			logic check_v;
			// External: odd pad reads back its even partner's output
			assign expect_v = (ext_pair_en[g] && (g % 2 == 1)) ? pad_out_r[g-((g%2==1)?1:0)] : pad_out_r[g];
			assign check_v  = (check_mode == SOR_MODE_INT) ? pad_oe_r[g]
			                : (check_mode == SOR_MODE_EXT) ? (ext_pair_en[g] && (g % 2 == 1) && !pad_oe_r[g])
			                : 1'b0;
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					mismatch_r[g] <= 1'b0;
				end else if (check_v && settle_r[3:0] == 4'h0 && pad_level_r[g] != expect_v) begin
					mismatch_r[g] <= 1'b1;
				end else if (dout_nxt[g] != dout_r[g]) begin
					mismatch_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pwm read-back capture
	// ----------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < SOR_NUM_CAPT; c++) begin : g_capt
			logic [SOR_RB_PATHS-1:0] src;
			// Timer 1 takes unit 1, timers 0 and 2 take unit 0
			assign src = SOR_CAPT_UNIT[c] ? pwm_unit_1_rb : pwm_unit_0_rb;
			sor_capture_mux #(
				.PATHS(SOR_RB_PATHS)
			) u_mux (
				.clk       (clk),
				.rst_n     (rst_n),
				.paths     (src),
				.sel       (capt_sel[c]),
				.captured_r(capt_value_r[c])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence masked_wr_s;
		masked_parallel_data_out_wr;
	endsequence

	analog_never_drives_a: assert property (@(posedge clk) disable iff (!rst_n)
		(analog_pad != '0) |=> ((pad_oe_r & $past(analog_pad)) == '0))
		else $error("analog pad enabled as output");

	masked_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		masked_wr_s |-> ##2 ((pad_out_r & ~$past(mpdo_mask, 2)) == ($past(dout_r, 2) & ~$past(mpdo_mask, 2))))
		else $error("unmasked pad changed");

	masked_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
		masked_wr_s |-> ##2 ((pad_out_r & $past(mpdo_mask, 2)) == ($past(mpdo_data, 2) & $past(mpdo_mask, 2))))
		else $error("masked pads not updated together");

	level_path_a: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n |-> ##3 (pad_level_r == $past(pad_in, 3)))
		else $error("pad level not readable");

	dir_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n |=> (pad_oe_r == ($past(dir_out) & ~$past(analog_pad))))
		else $error("direction not applied");

	mismatch_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_n && check_mode == SOR_MODE_INT && pad_oe_r[0] && settle_r[3:0] == 4'h0 && pad_level_r[0] != pad_out_r[0])
		|=> mismatch_r[0])
		else $error("mismatch flag missed");

	capt_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_n && capt_sel[1] < 3'd6) |=> (capt_value_r[1] == $past(pwm_unit_1_rb[capt_sel[1]])))
		else $error("timer 1 not on pwm unit 1");

	capt_mux_a: assert property (@(posedge clk) disable iff (!rst_n)
		(capt_sel[0] >= 3'd6) |=> !capt_value_r[0])
		else $error("out of range read-back path");

	// Timer 2 shares pwm unit 0 with timer 0
	capt_share_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_n && capt_sel[2] < 3'd6) |=> (capt_value_r[2] == $past(pwm_unit_0_rb[capt_sel[2]])))
		else $error("timer 2 not on pwm unit 0");

	// Off mode never raises a flag, even with a bad pad level
	off_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_n && check_mode == SOR_MODE_OFF && mismatch_r == '0) |=> (mismatch_r == '0))
		else $error("mismatch flag raised in off mode");

endmodule

// File: design/sor_pkg.sv
package sor_pkg;

	// ----------------------------------------------------------------
	// Pad and group sizing
	// ----------------------------------------------------------------
	localparam int SOR_NUM_PADS    = 16;
	localparam int SOR_GROUP_WIDTH = 16;
	localparam int SOR_NUM_PWM_UNITS = 2;
	localparam int SOR_PWM_SUBMODS   = 3;
	localparam int SOR_RB_PATHS      = 6;
	localparam int SOR_RB_SEL_W      = 3;
	localparam int SOR_NUM_CAPT      = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] SOR_DOUT_RST   = 16'h0000;
	localparam logic [15:0] SOR_DIR_RST    = 16'h0000;
	localparam logic [15:0] SOR_ANALOG_RST = 16'h0000;
	localparam logic [2:0]  SOR_SEL_RST    = 3'h0;

	// ----------------------------------------------------------------
	// Capture timer to pwm unit pairing
	// ----------------------------------------------------------------
	localparam logic [2:0] SOR_CAPT_UNIT = 3'b010;

	// Read-back checking mode
	typedef enum logic [2:0] {
		SOR_MODE_OFF = 3'b001,
		SOR_MODE_INT = 3'b010,
		SOR_MODE_EXT = 3'b100
	} sor_mode_t;

endpackage

// File: design/sor_capture_mux.sv
`timescale 1ns/10ps
// Selects one of six pwm read-back paths for a capture timer channel
module sor_capture_mux
	import sor_pkg::*;
#(
	parameter int PATHS = SOR_RB_PATHS
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// Selection
	input  wire logic [PATHS-1:0]        paths,
	input  wire logic [SOR_RB_SEL_W-1:0] sel,
	// Captured value
	output logic                         captured_r
);

	// Registered pick; out-of-range selects read low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			captured_r <= 1'b0;
		end else if (32'(sel) < PATHS) begin
			captured_r <= paths[sel];
		end else begin
			captured_r <= 1'b0;
		end
	end

endmodule

// File: bench/sor_pad_loop.sv
`timescale 1ns/10ps
// Actuators and loopback wiring on the pads
module sor_pad_loop
	import sor_pkg::*;
(
	// Clock
	input  wire logic                    clk,
	// Pad side of the block
	input  wire logic [SOR_NUM_PADS-1:0] pad_out_r,
	input  wire logic [SOR_NUM_PADS-1:0] pad_oe_r,
	input  wire logic [SOR_NUM_PADS-1:0] ext_pair_en,
	// Commanded wiring faults
	input  wire logic [SOR_NUM_PADS-1:0] fault,
	output logic      [SOR_NUM_PADS-1:0] pad_in
);
	logic float_r;

	// Undriven pads wander, so a stale level is never trusted
	initial float_r = 1'b0;
	always @(posedge clk) float_r <= ~float_r;

	// Driven pads read their own level, loop pads the even neighbour
	always_comb begin
		for (int i = 0; i < SOR_NUM_PADS; i++) begin
			pad_in[i] = float_r ^ i[0];
			if (pad_oe_r[i])
				pad_in[i] = pad_out_r[i] ^ fault[i];
			else if (i[0] && ext_pair_en[i] && pad_oe_r[i-1])
				pad_in[i] = pad_out_r[i-1] ^ fault[i];
		end
	end
endmodule

// File: bench/safe_output_readback_test.sv
`timescale 1ns/10ps
module safe_output_readback_test
	import sor_pkg::*;
;
	logic        clk, rst_n, pad_wr, mpdo_wr;
	logic [15:0] analog_pad, dir_out, ext_pair_en, pad_wr_sel, pad_wr_data, mpdo_mask, mpdo_data;
	logic [15:0] fault, pad_in, pad_out_r, pad_oe_r, pad_level_r, mismatch_r;
	logic [2:0]  check_mode, capt_value_r, exp3;
	logic [5:0]  rb0, rb1;
	logic [2:0]  capt_sel [SOR_NUM_CAPT];
	logic [15:0] r_mask [4], r_data [4], r_exp [4];
	int          err_count, tests_run, cycles;

	// ----------------------------------------------------------------
	// Design, pad wiring and clock
	// ----------------------------------------------------------------
	sor_safe_output u_dut (.clk(clk), .rst_n(rst_n), .analog_pad(analog_pad), .dir_out(dir_out),
		.ext_pair_en(ext_pair_en), .check_mode(check_mode), .pad_wr(pad_wr), .pad_wr_sel(pad_wr_sel),
		.pad_wr_data(pad_wr_data), .masked_parallel_data_out_wr(mpdo_wr), .mpdo_mask(mpdo_mask),
		.mpdo_data(mpdo_data), .pad_in(pad_in), .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r),
		.pad_level_r(pad_level_r), .mismatch_r(mismatch_r), .pwm_unit_0_rb(rb0), .pwm_unit_1_rb(rb1),
		.capt_sel(capt_sel), .capt_value_r(capt_value_r));
	sor_pad_loop u_loop (.clk(clk), .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r),
		.ext_pair_en(ext_pair_en), .fault(fault), .pad_in(pad_in));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard, well above the roughly 155 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic end_of_test();
		if (err_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Wait n rising edges, then step 1 ns past the last one
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic mw(logic [15:0] m, logic [15:0] d);
		@(posedge clk) begin
			mpdo_wr <= 1'b1;
			mpdo_mask <= m;
			mpdo_data <= d;
		end
		@(posedge clk) mpdo_wr <= 1'b0;
		cyc(2);
	endtask

	task automatic pw(logic [15:0] s, logic [15:0] d);
		@(posedge clk) begin
			pad_wr <= 1'b1;
			pad_wr_sel <= s;
			pad_wr_data <= d;
		end
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_n, pad_wr, mpdo_wr, pad_wr_sel, pad_wr_data, mpdo_mask, mpdo_data, fault} = '0;
		{analog_pad, ext_pair_en} = '0;
		dir_out = 16'hffff;
		check_mode = SOR_MODE_INT;
		rb0 = 6'h2d;
		rb1 = 6'h12;
		capt_sel = '{default: 3'h0};
		r_mask = '{16'hffff, 16'h00f0, 16'h8001, 16'h0000};
		r_data = '{16'ha5a5, 16'h0000, 16'h0000, 16'hffff};
		r_exp = '{16'ha5a5, 16'ha505, 16'h2504, 16'h2504};
		cyc(20);
		chk("reset", 16'h0000, pad_out_r | pad_oe_r | pad_level_r | mismatch_r | 16'(capt_value_r));
		@(posedge clk) begin
			rst_n <= 1'b1;
			analog_pad <= 16'h8000;
		end
		for (int i = 0; i < 4; i++) begin
			mw(r_mask[i], r_data[i]);
			chk("masked out", r_exp[i], pad_out_r);
		end
		chk("oe", 16'h7fff, pad_oe_r);
		// Back-to-back single writes, then a masked write racing one
		pw(16'h0003, 16'h0001);
		pw(16'h000c, 16'h0008);
		// Last single write and a masked write land on the same edge
		@(posedge clk) begin
			pad_wr_sel <= 16'hffff;
			pad_wr_data <= 16'h0000;
			mpdo_wr <= 1'b1;
			mpdo_mask <= 16'h00f0;
			mpdo_data <= 16'h00f0;
		end
		@(posedge clk) begin
			pad_wr <= 1'b0;
			mpdo_wr <= 1'b0;
		end
		cyc(3);
		chk("single out", 16'h25f9, pad_out_r);
		cyc(12);
		chk("int level", 16'h25f9, pad_level_r & 16'h7fff);
		chk("int clean", 16'h0000, mismatch_r);
		@(posedge clk) fault <= 16'h0001;
		cyc(12);
		chk("int fault", 16'h0001, mismatch_r);
		@(posedge clk) fault <= 16'h0000;
		// Let the clean level reach the flag first, else the set wins over the clear
		cyc(6);
		pw(16'h0001, 16'h0000);
		@(posedge clk) pad_wr <= 1'b0;
		cyc(12);
		chk("int clear", 16'h0000, mismatch_r);
		@(posedge clk) begin
			check_mode <= SOR_MODE_OFF;
			fault <= 16'h0002;
		end
		cyc(12);
		chk("off mode", 16'h0000, mismatch_r);
		// External loop: even pads drive, odd pads read them back
		@(posedge clk) begin
			rst_n <= 1'b0;
			fault <= 16'h0000;
			{analog_pad, dir_out, ext_pair_en} <= {16'h0000, 16'h5555, 16'haaaa};
			check_mode <= SOR_MODE_EXT;
		end
		@(posedge clk) rst_n <= 1'b1;
		mw(16'hffff, 16'h0055);
		cyc(12);
		chk("ext level", 16'h00ff, pad_level_r);
		chk("ext clean", 16'h0000, mismatch_r);
		@(posedge clk) fault <= 16'h0002;
		cyc(12);
		chk("ext fault", 16'h0002, mismatch_r);
		chk("ext oe", 16'h5555, pad_oe_r);
		// Every path select, plus one beyond the six paths
		for (int s = 0; s < 7; s++) begin
			@(posedge clk) capt_sel <= '{default: 3'(s)};
			cyc(2);
			exp3 = (s < 6) ? {rb0[s], rb1[s], rb0[s]} : 3'h0;
			chk("capture", 16'(exp3), 16'(capt_value_r));
		end
		end_of_test();
	end
endmodule
